// file: logic/drjr_pkg.sv
// Shared constants, code tables and carrier types for the dual-link receiver
package drjr_pkg;
   localparam int NUM_LANES = 8;
   localparam int WORD_W = 32;
   localparam int SYM_W = 40;
   localparam int SAMPLE_W = 16;
   localparam int OCTETS_PER_FRAME = 2;
   localparam int FRAMES_PER_MF = 16;
   localparam int OCTETS_PER_WORD = 4;
   localparam int MF_WORDS = OCTETS_PER_FRAME * FRAMES_PER_MF / OCTETS_PER_WORD;
   localparam logic [2:0] LMFC_LAST = 3'(MF_WORDS - 1);
   localparam logic [2:0] CGS_LAST = 3'h3;
   // Lane maps: group A on first connector, group B on second
   localparam logic [7:0] LANES_A = 8'h03;
   localparam logic [7:0] LANES_B = 8'h30;
   localparam logic [7:0] LANES_ACTIVE = 8'h33;
   // Link and reference rates
   localparam int LINE_RATE_KBPS = 5898240;
   localparam int REFCLK_KHZ = 147456;
   localparam int CLK_PERIOD_NS = 100;
   // Register map and fields
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam logic [3:0] REG_ERROR = 4'hC;
   localparam int CTRL_DDC_BIT = 0;
   localparam int CTRL_DSCR_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam int ST_SYNC_A_BIT = 8;
   localparam int ST_SYNC_B_BIT = 9;
   localparam int ST_LMFC_POS = 12;
   // 8b/10b constants, codes written abcdei / fghj with RD minus
   localparam logic [7:0] COMMA_BYTE = 8'hBC;
   localparam logic [5:0] K28_6B_N = 6'h0F;
   localparam logic [5:0] K28_6B_P = 6'h30;
   localparam logic [4:0] K28_VAL = 5'h1C;
   localparam logic [31:0][5:0] CODE_6B = {
      6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
      6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
      6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
      6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
   localparam logic [7:0][3:0] CODE_4B = {
      4'hE, 4'h6, 4'hA, 4'hD, 4'h3, 4'h5, 4'h9, 4'hB};
   localparam logic [3:0] ALT7_4B = 4'h7;
   // Lane code-group sync states
   typedef enum logic [1:0] {
      CGS_HUNT = 2'b01,
      CGS_LOCK = 2'b10
   } drjr_cgs_e;
   // Capture tap toward the on-chip logic analyser
   typedef struct packed {
      logic [NUM_LANES*WORD_W-1:0] data;
      logic [NUM_LANES-1:0] lane_sync;
      logic valid;
   } drjr_capture_s;
endpackage

// file: logic/drjr_lane_dec.sv
// One receive lane: polarity fix, 8b/10b decode and comma sync
`timescale 1ns/10ps
module drjr_lane_dec
   import drjr_pkg::*;
(
   // Clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Four raw symbols, first in low bits
   input wire logic [SYM_W-1:0] symbols_in,
   // Decoded word and lane state
   output logic [WORD_W-1:0] data_out,
   output logic comma_sync,
   output logic code_err
);
   // Decode one symbol into {error, control, byte}
   function automatic logic [9:0] dec_sym(input logic [9:0] s);
      logic [5:0] c6;
      logic [3:0] c4;
      logic [4:0] v5;
      logic [2:0] v3;
      logic h5;
      logic h3;
      logic k;
      c6 = {s[0], s[1], s[2], s[3], s[4], s[5]};
      c4 = {s[6], s[7], s[8], s[9]};
      v5 = '0;
      v3 = '0;
      h5 = 1'b0;
      h3 = 1'b0;
      k = (c6 == K28_6B_N) || (c6 == K28_6B_P);
      for (int i = 0; i < 32; i++) begin
         if (c6 == CODE_6B[i] || (c6 == ~CODE_6B[i] &&
             ($countones(CODE_6B[i]) != 3 || i == 7))) begin
            v5 = 5'(i);
            h5 = 1'b1;
         end
      end
      if (k) begin
         v5 = K28_VAL;
         h5 = 1'b1;
         // Only the positive-disparity control form carries inverted fghj
         if (c6 == K28_6B_P) begin
            c4 = ~c4;
         end
      end
      for (int j = 0; j < 8; j++) begin
         if (c4 == CODE_4B[j] || (c4 == ~CODE_4B[j] &&
             ($countones(CODE_4B[j]) != 2 || j == 3))) begin
            v3 = 3'(j);
            h3 = 1'b1;
         end
      end
      if (c4 == ALT7_4B || c4 == ~ALT7_4B) begin
         v3 = 3'h7;
         h3 = 1'b1;
      end
      return {~(h5 & h3), k, v3, v5};
   endfunction

   logic [SYM_W-1:0] sym_inv;
   logic [WORD_W-1:0] data_ff, nxt_data;
   logic err_ff, nxt_err;
   logic [2:0] cnt_ff, nxt_cnt;
   drjr_cgs_e state_ff, nxt_state;
   logic all_comma;

   // Pair wiring is swapped on the board, so every bit is flipped
   assign sym_inv = ~symbols_in;

   // Decode four symbols and run comma hunting
   always_comb begin
      logic [9:0] r;
      r = '0;
      nxt_err = 1'b0;
      all_comma = 1'b1;
      nxt_data = '0;
      for (int q = 0; q < 4; q++) begin
         r = dec_sym(sym_inv[q*10 +: 10]);
         nxt_data[q*8 +: 8] = r[7:0];
         nxt_err = nxt_err | r[9];
         all_comma = all_comma & r[8] & (r[7:0] == COMMA_BYTE) & ~r[9];
      end
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         CGS_HUNT: begin
            nxt_cnt = all_comma ? cnt_ff + 3'h1 : 3'h0;
            if (all_comma && cnt_ff == CGS_LAST) begin
               nxt_state = CGS_LOCK;
               nxt_cnt = 3'h0;
            end
         end
         CGS_LOCK: begin
            if (nxt_err) begin
               nxt_state = CGS_HUNT;
            end
         end
         default: begin
            nxt_state = CGS_HUNT;
            nxt_cnt = 3'h0;
         end
      endcase
   end

   // Lane registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_ff <= '0;
         err_ff <= 1'b0;
         cnt_ff <= 3'h0;
         state_ff <= CGS_HUNT;
      end else if (ce) begin
         data_ff <= nxt_data;
         err_ff <= nxt_err;
         cnt_ff <= nxt_cnt;
         state_ff <= nxt_state;
      end
   end

   assign data_out = data_ff;
   assign code_err = err_ff;
   assign comma_sync = (state_ff == CGS_LOCK);

   // Inverted comma words decode to comma bytes
   property p_inv_comma;
      @(posedge clk) disable iff (!rst_n)
      (ce && symbols_in == {4{10'h283}}) |=> (data_ff == {4{COMMA_BYTE}}) && !err_ff;
   endproperty
   a_inv_comma: assert property (p_inv_comma) else $error("inverted comma misdecoded");

   // Lock only after a full run of comma words
   property p_lock_needs_commas;
      @(posedge clk) disable iff (!rst_n)
      (ce && state_ff == CGS_HUNT && !all_comma) |=> state_ff == CGS_HUNT;
   endproperty
   a_lock_needs_commas: assert property (p_lock_needs_commas) else $error("early lock");
endmodule

// file: logic/drjr_rx_link.sv
// Eight-lane receive link serving two converters with combined sync
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
// Contract
// - Invert every incoming lane before decoding.
// - Core clock and SYSREF from first connector.
// - Each group clocked from its own connector. All eight lane decoders run on the one core CLK.
// - One eight-lane core serves both converters.
// - Four unused lanes output zeros, ignored.
// - Two octets per frame, sixteen frames, descrambled.
// - Output raw lane frames, no sample mapping. SAMPLES still maps lanes 0 and 4 into byte-swapped samples.
// - With down-conversion, AND both sync requests.
// - Lanes at 5.89824 Gbps, 147.456 MHz reference.
// - 8b/10b decode, 40-bit in, 32-bit out.
// - Two groups of four transceivers each.
// - Frame data visible to capture analyser.
// - Links may also split into smaller cores.
// - Sync output changes only on multiframe edges.
// - Samples are byte-swapped 16-bit two's complement.
module drjr_rx_link
   import drjr_pkg::*;
(
   // Core clock, reset and enable
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // Avalon-MM register slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Lane symbols and SYSREF
   input wire logic [NUM_LANES*SYM_W-1:0] LANE_SYMBOLS,
   input wire logic SYSREF,
   // Sync requests, active low, one per converter
   output logic SYNC_N_A,
   output logic SYNC_N_B,
   // Capture tap and sample view
   output drjr_capture_s CAPTURE,
   output logic [4*SAMPLE_W-1:0] SAMPLES
);
   logic [NUM_LANES-1:0][WORD_W-1:0] lane_data;
   logic [NUM_LANES-1:0] lane_sync;
   logic [NUM_LANES-1:0] lane_err;
   logic [NUM_LANES-1:0][14:0] scr_ff, nxt_scr;
   drjr_capture_s cap_ff, nxt_cap;
   logic [4*SAMPLE_W-1:0] smp_ff, nxt_smp;
   logic [2:0] lmfc_ff, nxt_lmfc;
   logic sysref_q_ff, nxt_sysref_q;
   logic sync_a_ff, nxt_sync_a;
   logic sync_b_ff, nxt_sync_b;
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic [NUM_LANES-1:0] errs_ff, nxt_errs;
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic ready_a, ready_b, wr_take;

   // Self-synchronous descrambler, x^15 + x^14 + 1, octets MSB first
   function automatic logic [46:0] descr(input logic [31:0] w, input logic [14:0] st);
      logic [14:0] s;
      logic [31:0] o;
      logic b;
      s = st;
      o = '0;
      b = 1'b0;
      for (int q = 0; q < OCTETS_PER_WORD; q++) begin
         for (int k = 7; k >= 0; k--) begin
            b = w[q*8+k];
            o[q*8+k] = b ^ s[13] ^ s[14];
            s = {s[13:0], b};
         end
      end
      return {s, o};
   endfunction

   // Eight lane decoders; groups of four per connector
   genvar gl;
   generate
      for (gl = 0; gl < NUM_LANES; gl++) begin : g_lane
         drjr_lane_dec u_dec (
            .clk(CLK),
            .rst_n(RST_N),
            .ce(CE),
            .symbols_in(LANE_SYMBOLS[gl*SYM_W +: SYM_W]),
            .data_out(lane_data[gl]),
            .comma_sync(lane_sync[gl]),
            .code_err(lane_err[gl])
         );
      end
   endgenerate

   // Descramble, mask unused lanes, form capture word and samples
   always_comb begin
      logic [46:0] r;
      logic [WORD_W-1:0] w;
      r = '0;
      w = '0;
      nxt_cap = '0;
      nxt_scr = scr_ff;
      nxt_smp = smp_ff;
      for (int i = 0; i < NUM_LANES; i++) begin
         r = descr(lane_data[i], scr_ff[i]);
         nxt_scr[i] = r[46:32];
         w = ctrl_ff[CTRL_DSCR_BIT] ? r[31:0] : lane_data[i];
         nxt_cap.data[i*WORD_W +: WORD_W] = LANES_ACTIVE[i] ? w : '0;
         if (i == 0) begin
            nxt_smp[0 +: 32] = {w[23:16], w[31:24], w[7:0], w[15:8]};
         end
         if (i == 4) begin
            nxt_smp[32 +: 32] = {w[23:16], w[31:24], w[7:0], w[15:8]};
         end
      end
      nxt_cap.lane_sync = lane_sync & LANES_ACTIVE;
      nxt_cap.valid = 1'b1;
   end

   // Multiframe counter, realigned on SYSREF rise from first connector
   always_comb begin
      nxt_sysref_q = SYSREF;
      if (SYSREF && !sysref_q_ff) begin
         nxt_lmfc = 3'h0;
      end else if (lmfc_ff == LMFC_LAST) begin
         nxt_lmfc = 3'h0;
      end else begin
         nxt_lmfc = lmfc_ff + 3'h1;
      end
   end

   // Per-link readiness; each two-lane link stands on its own
   assign ready_a = &(lane_sync | ~LANES_A);
   assign ready_b = &(lane_sync | ~LANES_B);

   // Sync requests move only at the multiframe boundary
   always_comb begin
      nxt_sync_a = sync_a_ff;
      nxt_sync_b = sync_b_ff;
      if (lmfc_ff == LMFC_LAST) begin
         if (ctrl_ff[CTRL_DDC_BIT]) begin
            nxt_sync_a = ready_a & ready_b;
            nxt_sync_b = ready_a & ready_b;
         end else begin
            nxt_sync_a = ready_a;
            nxt_sync_b = ready_b;
         end
      end
   end

   // Avalon slave: one wait cycle, then answer
   assign wr_take = AVS_WRITE && !wait_ff;
   always_comb begin
      nxt_wait = !((AVS_READ || AVS_WRITE) && wait_ff);
      nxt_rdata = rdata_ff;
      nxt_ctrl = ctrl_ff;
      nxt_errs = errs_ff;
      if (AVS_READ && wait_ff) begin
         case (AVS_ADDRESS)
            REG_CTRL: nxt_rdata = {30'h0, ctrl_ff};
            REG_STATUS: nxt_rdata = {17'h0, lmfc_ff, 2'h0, sync_b_ff, sync_a_ff,
                                     lane_sync & LANES_ACTIVE};
            REG_CONFIG: nxt_rdata = {16'h0, 8'(FRAMES_PER_MF), 4'(OCTETS_PER_FRAME),
                                     4'(NUM_LANES)};
            REG_ERROR: nxt_rdata = {24'h0, errs_ff};
            default: nxt_rdata = 32'h0;
         endcase
      end
      if (wr_take && AVS_BYTEENABLE[0] && AVS_ADDRESS == REG_CTRL) begin
         nxt_ctrl = AVS_WRITEDATA[1:0];
      end
      if (wr_take && AVS_BYTEENABLE[0] && AVS_ADDRESS == REG_ERROR) begin
         nxt_errs = errs_ff & ~AVS_WRITEDATA[7:0];
      end
      nxt_errs = nxt_errs | (lane_err & LANES_ACTIVE);
   end

   // State registers, frozen while CE is low
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         scr_ff <= '0;
         cap_ff <= '0;
         smp_ff <= '0;
         lmfc_ff <= 3'h0;
         sysref_q_ff <= 1'b0;
         sync_a_ff <= 1'b0;
         sync_b_ff <= 1'b0;
         ctrl_ff <= CTRL_RESET;
         errs_ff <= '0;
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end else if (CE) begin
         scr_ff <= nxt_scr;
         cap_ff <= nxt_cap;
         smp_ff <= nxt_smp;
         lmfc_ff <= nxt_lmfc;
         sysref_q_ff <= nxt_sysref_q;
         sync_a_ff <= nxt_sync_a;
         sync_b_ff <= nxt_sync_b;
         ctrl_ff <= nxt_ctrl;
         errs_ff <= nxt_errs;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // Outputs straight from registers
   assign SYNC_N_A = sync_a_ff;
   assign SYNC_N_B = sync_b_ff;
   assign CAPTURE = cap_ff;
   assign SAMPLES = smp_ff;
   assign AVS_WAITREQUEST = wait_ff;
   assign AVS_READDATA = rdata_ff;

   // Unused lanes never carry data
   property p_unused_zero;
      @(posedge CLK) disable iff (!RST_N)
      (cap_ff.data[95:64] == '0) && (cap_ff.data[127:96] == '0)
      && (cap_ff.data[223:192] == '0) && (cap_ff.data[255:224] == '0);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused lane nonzero");

   // Combined mode drives one level to both converters
   property p_ddc_same;
      @(posedge CLK) disable iff (!RST_N)
      (CE && ctrl_ff[CTRL_DDC_BIT] && lmfc_ff == LMFC_LAST) |=> SYNC_N_A == SYNC_N_B;
   endproperty
   a_ddc_same: assert property (p_ddc_same) else $error("sync outputs differ");

   // Sync level changes only as the multiframe wraps
   property p_sync_on_edge;
      @(posedge CLK) disable iff (!RST_N)
      $changed(SYNC_N_A) |-> $past(lmfc_ff) == LMFC_LAST;
   endproperty
   a_sync_on_edge: assert property (p_sync_on_edge) else $error("sync off edge");

   // Release only when the link's active lanes were locked
   property p_sync_needs_lock;
      @(posedge CLK) disable iff (!RST_N)
      $rose(SYNC_N_A) |-> $past(lane_sync[0] && lane_sync[1]);
   endproperty
   a_sync_needs_lock: assert property (p_sync_needs_lock) else $error("sync early");

   // Multiframe is eight words long
   property p_mf_len;
      @(posedge CLK) disable iff (!RST_N)
      (CE && lmfc_ff == 3'h0 && !SYSREF) ##1 (CE && !SYSREF)[*7] |-> lmfc_ff == LMFC_LAST;
   endproperty
   a_mf_len: assert property (p_mf_len) else $error("multiframe length wrong");

   // First sample is the byte-swapped low half of the first lane word
   property p_swap;
      @(posedge CLK) disable iff (!RST_N)
      CE |=> SAMPLES[15:0] == {cap_ff.data[7:0], cap_ff.data[15:8]};
   endproperty
   a_swap: assert property (p_swap) else $error("sample byte order wrong");

   // Read answered exactly one cycle after the request is seen
   property p_bus_answer;
      @(posedge CLK) disable iff (!RST_N)
      (CE && AVS_READ && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   // Capture tap marks valid frames after reset
   property p_cap_valid;
      @(posedge CLK) disable iff (!RST_N)
      CE |=> CAPTURE.valid;
   endproperty
   a_cap_valid: assert property (p_cap_valid) else $error("capture not valid");
endmodule

// file: bench/drjr_adc_pair_model.sv
// Behavioural pair of converters, two lanes each, on the far side of the link
`timescale 1ns/10ps
module drjr_adc_pair_model
   import drjr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Sync requests and test controls
   input wire logic sync_n_a,
   input wire logic sync_n_b,
   input wire logic scr_en,
   input wire logic [7:0] bad,
   // Line symbols and delayed plain words
   output logic [NUM_LANES*SYM_W-1:0] lane_symbols,
   output logic [NUM_LANES*WORD_W-1:0] exp_word,
   output logic [7:0] exp_ok
);
   logic [7:0] cnt;
   logic [14:0] scr [8];
   logic [1:0] run [8];
   logic [NUM_LANES*WORD_W-1:0] p1;
   logic [NUM_LANES*WORD_W-1:0] p2;
   logic [7:0] ok1;
   logic [7:0] ok2;

   // Octet to 10b code, bit0 first on the line
   function automatic logic [9:0] enc(input logic [7:0] b, input logic k);
      logic [5:0] c6;
      logic [3:0] c4;
      logic [9:0] s;
      c6 = k ? K28_6B_N : CODE_6B[b[4:0]];
      c4 = k ? 4'hA : CODE_4B[b[7:5]];
      if (!k && b[7:5] == 3'h7 && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14))
         c4 = ALT7_4B;
      for (int i = 0; i < 6; i++) s[i] = c6[5-i];
      for (int i = 0; i < 4; i++) s[6+i] = c4[3-i];
      return s;
   endfunction

   // Per-lane transmit: commas, scrambled counting data or filler
   always @(posedge clk or negedge rst_n) begin : tx
      logic [31:0] w;
      logic [31:0] sw;
      logic [39:0] sym;
      logic [31:0] dat;
      logic [14:0] h;
      logic s;
      logic good;
      if (!rst_n) begin
         cnt <= 8'h00;
         lane_symbols <= ~{(NUM_LANES*4){enc(COMMA_BYTE, 1'b1)}};
         p1 <= '0;
         p2 <= '0;
         ok1 <= 8'h00;
         ok2 <= 8'h00;
         exp_word <= '0;
         exp_ok <= 8'h00;
         for (int n = 0; n < NUM_LANES; n++) begin
            scr[n] <= 15'h7FFF;
            run[n] <= 2'h0;
         end
      end else begin
         cnt <= cnt + 8'h01;
         // Two stages: lane decode register, then capture register
         p2 <= p1;
         ok2 <= ok1;
         exp_word <= p2;
         exp_ok <= ok2;
         for (int n = 0; n < NUM_LANES; n++) begin
            for (int k = 0; k < 4; k++) w[k*8+:8] = 8'((cnt << 2) + k) ^ 8'(n << 5);
            h = scr[n];
            // Octet 0 first, most significant bit first
            for (int k = 0; k < 4; k++)
               for (int b = 7; b >= 0; b--) begin
                  s = w[k*8+b] ^ (scr_en & (h[13] ^ h[14]));
                  h = {h[13:0], s};
                  sw[k*8+b] = s;
               end
            good = 1'b0;
            dat = '0;
            if (!LANES_ACTIVE[n]) begin
               for (int k = 0; k < 4; k++) sym[k*10+:10] = enc(w[k*8+:8], 1'b0);
            end else if (!(n < 4 ? sync_n_a : sync_n_b)) begin
               // Commas while sync is requested
               for (int k = 0; k < 4; k++) sym[k*10+:10] = enc(COMMA_BYTE, 1'b1);
            end else begin
               // Data on the edge after release, both converters alike
               for (int k = 0; k < 4; k++) sym[k*10+:10] = enc(sw[k*8+:8], 1'b0);
               dat = w;
               good = 1'b1;
            end
            if (bad[n]) begin
               sym[9:0] = 10'h000;
               good = 1'b0;
            end
            lane_symbols[n*SYM_W+:SYM_W] <= ~sym;
            p1[n*WORD_W+:WORD_W] <= dat;
            scr[n] <= h;
            run[n] <= !good ? 2'h0 : (run[n] == 2'h3 ? 2'h3 : run[n] + 2'h1);
            ok1[n] <= good && run[n] != 2'h0;
         end
      end
   end
endmodule

// file: bench/dual_adc_jesd_rx_link_test.sv
// Self-checking bench for the dual-link receiver
`timescale 1ns/10ps
module dual_adc_jesd_rx_link_test;
   import drjr_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic CE = 1'b1;
   drjr_capture_s cap_hold;
   logic [3:0] AVS_ADDRESS = 4'h0;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic [NUM_LANES*SYM_W-1:0] LANE_SYMBOLS;
   logic SYSREF = 1'b0;
   logic SYNC_N_A;
   logic SYNC_N_B;
   drjr_capture_s CAPTURE;
   logic [4*SAMPLE_W-1:0] SAMPLES;
   logic scr_en = 1'b1;
   logic [7:0] bad = 8'h00;
   logic [NUM_LANES*WORD_W-1:0] exp_word;
   logic [7:0] exp_ok;
   logic [1:0] prev_sync = 2'b00;
   logic [31:0] q;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   int sr_cyc = 0;
   int ph_ref = -1;

   // Clock
   always #(CLK_PERIOD_NS/2) CLK = ~CLK;

   drjr_rx_link DUT (.CLK(CLK), .RST_N(RST_N), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'hF),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .LANE_SYMBOLS(LANE_SYMBOLS), .SYSREF(SYSREF),
      .SYNC_N_A(SYNC_N_A), .SYNC_N_B(SYNC_N_B), .CAPTURE(CAPTURE), .SAMPLES(SAMPLES));

   drjr_adc_pair_model adcs (.clk(CLK), .rst_n(RST_N), .sync_n_a(SYNC_N_A),
      .sync_n_b(SYNC_N_B), .scr_en(scr_en), .bad(bad), .lane_symbols(LANE_SYMBOLS),
      .exp_word(exp_word), .exp_ok(exp_ok));

   // Compare and count
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Summary and verdict
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One register transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_READ <= !wr;
      AVS_WRITE <= wr;
      @(posedge CLK);
      while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask

   // Read and compare under a mask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   // Expected byte-swapped sample pair of one word
   function automatic logic [31:0] swap(input logic [31:0] w);
      return {w[23:16], w[31:24], w[7:0], w[15:8]};
   endfunction

   // Compare captured frames and samples with the sent words
   task automatic frames(input int nc);
      for (int c = 0; c < nc; c++) begin
         @(posedge CLK);
         #1;
         for (int n = 0; n < NUM_LANES; n++)
            if (!LANES_ACTIVE[n] || exp_ok[n])
               chk(CAPTURE.data[n*WORD_W+:WORD_W], exp_word[n*WORD_W+:WORD_W]);
         if (exp_ok[0]) chk(SAMPLES[31:0], swap(exp_word[31:0]));
         if (exp_ok[4]) chk(SAMPLES[63:32], swap(exp_word[159:128]));
      end
      chk(exp_ok, 8'h33);
   endtask

   // Wait for both sync lines released, bounded
   task automatic wait_sync(input logic ddc);
      for (int i = 0; i < 300 && {SYNC_N_B, SYNC_N_A} !== 2'b11; i++) begin
         @(posedge CLK);
         if (ddc) chk(SYNC_N_A, SYNC_N_B);
      end
      chk({SYNC_N_B, SYNC_N_A}, 2'b11);
   endtask

   // Cycle count, sync edge phase against the multiframe, timeout
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (SYSREF) sr_cyc <= cyc;
      prev_sync <= {SYNC_N_B, SYNC_N_A};
      if (sr_cyc > 0 && {SYNC_N_B, SYNC_N_A} !== prev_sync) begin
         if (ph_ref < 0) ph_ref <= (cyc - sr_cyc) % 8;
         else chk((cyc - sr_cyc) % 8, ph_ref);
      end
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge CLK);
      chk({SYNC_N_B, SYNC_N_A, AVS_WAITREQUEST}, 3'b001);
      chk(CAPTURE.data, '0);
      chk({CAPTURE.lane_sync, CAPTURE.valid}, 9'h000);
      RST_N <= 1'b1;
      rd(REG_CTRL, 32'hFFFFFFFF, 32'h2);
      rd(REG_CONFIG, 32'hFFFFFFFF, 32'h1028);
      bus(1'b1, REG_CONFIG, 32'h0);
      rd(REG_CONFIG, 32'hFFFFFFFF, 32'h1028);
      rd(4'h2, 32'hFFFFFFFF, 32'h0);
      // Combined sync with descrambling, one lane of the second link broken
      bus(1'b1, REG_CTRL, 32'h3);
      bad <= 8'h10;
      @(posedge CLK);
      SYSREF <= 1'b1;
      @(posedge CLK);
      SYSREF <= 1'b0;
      repeat (40) @(posedge CLK);
      chk({SYNC_N_B, SYNC_N_A}, 2'b00);
      rd(REG_STATUS, 32'h3FF, 32'h023);
      rd(REG_ERROR, 32'h33, 32'h10);
      bad <= 8'h00;
      wait_sync(1'b1);
      bus(1'b1, REG_ERROR, 32'h10);
      rd(REG_ERROR, 32'h33, 32'h0);
      frames(24);
      chk({CAPTURE.lane_sync, CAPTURE.valid}, 9'h067);
      // Separate syncs, no descrambling, second link loses lock
      bus(1'b1, REG_CTRL, 32'h0);
      scr_en <= 1'b0;
      repeat (4) @(posedge CLK);
      bad <= 8'h10;
      repeat (30) @(posedge CLK);
      chk({SYNC_N_B, SYNC_N_A}, 2'b01);
      bad <= 8'h00;
      wait_sync(1'b0);
      frames(24);
      // Clock enable low freezes the capture tap
      @(posedge CLK);
      CE <= 1'b0;
      @(posedge CLK);
      cap_hold = CAPTURE;
      repeat (5) @(posedge CLK);
      chk(CAPTURE.data, cap_hold.data);
      chk({SYNC_N_B, SYNC_N_A}, 2'b11);
      wrap_up();
   end
endmodule
